// ==== stk_regs.svh ====
`ifndef STK_REGS_SVH
`define STK_REGS_SVH

`define STK_OPC_POP_USER_INC 8'h93
`define STK_OPC_PUSH_DIRECT 8'h70
`define STK_OPC_PUSH_INDIRECT 8'h71
`define STK_OPC_PUSH_USER_DEC 8'h82
`define STK_INSTR_CYCLES 3'h7
`define STK_STACK_POINTER_RESET 16'h0000
`define STK_BYTE_RESET 8'h00

`endif

// ==== stk_pkg.sv ====
package stk_pkg;

  // gray codes along idle -> fetch -> fetch -> update -> store -> hold
  typedef enum logic [2:0] {
    stk_idle = 3'b000,
    stk_fetch_ptr = 3'b001,
    stk_fetch_data = 3'b011,
    stk_update = 3'b010,
    stk_store = 3'b110,
    stk_hold = 3'b111
  } stk_state_t;

  typedef struct packed {
    stk_state_t state;
    logic [2:0] cnt;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] ptr;
    logic [7:0] data;
    logic [15:0] system_stack_pointer;
    logic rf_we;
    logic [7:0] rf_wa;
    logic [7:0] rf_wd;
    logic [7:0] rf_ra;
    logic mem_we;
    logic [15:0] mem_a;
    logic [7:0] mem_wd;
    logic illegal;
  } stk_regs_t;

endpackage

// ==== stk_exec.sv ====
`timescale 1ns/10ps
`include "stk_regs.svh"

module stk_exec (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  output logic ready,
  output logic done,
  output logic illegal_op,
  output logic [7:0] rf_rd_addr,
  input wire logic [7:0] rf_rd_data,
  output logic rf_we,
  output logic [7:0] rf_wr_addr,
  output logic [7:0] rf_wr_data,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wr_data,
  input wire logic stack_pointer_load,
  input wire logic [15:0] stack_pointer_load_value,
  output logic [7:0] stack_pointer_high_byte,
  output logic [7:0] stack_pointer_low_byte
);

  stk_pkg::stk_regs_t r;
  stk_pkg::stk_regs_t next_r;

  function automatic logic is_known(input logic [7:0] opc);
    is_known = (opc == `STK_OPC_POP_USER_INC) ||
               (opc == `STK_OPC_PUSH_DIRECT) ||
               (opc == `STK_OPC_PUSH_INDIRECT) ||
               (opc == `STK_OPC_PUSH_USER_DEC);
  endfunction

  function automatic logic is_sys_push(input logic [7:0] opc);
    is_sys_push = (opc == `STK_OPC_PUSH_DIRECT) ||
                  (opc == `STK_OPC_PUSH_INDIRECT);
  endfunction

  function automatic logic is_user_pop(input logic [7:0] opc);
    is_user_pop = (opc == `STK_OPC_POP_USER_INC);
  endfunction

  function automatic logic is_user_push(input logic [7:0] opc);
    is_user_push = (opc == `STK_OPC_PUSH_USER_DEC);
  endfunction

  always_comb begin
    next_r = r;
    next_r.rf_we = 1'b0;
    next_r.mem_we = 1'b0;
    next_r.illegal = 1'b0;
    // length follows the counter, not the state path, so the shorter
    // direct push still occupies all seven cycles
    if (r.state != stk_pkg::stk_idle) begin
      next_r.cnt = r.cnt + 3'd1;
    end
    unique case (r.state)
      stk_pkg::stk_idle: begin
        next_r.cnt = 3'd0;
        // pointer loads only between instructions so a push sees one value
        if (stack_pointer_load) begin
          next_r.system_stack_pointer = stack_pointer_load_value;
        end
        if (start) begin
          if (is_known(opcode)) begin
            next_r.op = opcode;
            next_r.b1 = operand1;
            next_r.b2 = operand2;
            next_r.rf_ra = operand1;
            next_r.cnt = 3'd1;
            next_r.state = stk_pkg::stk_fetch_ptr;
          end else begin
            next_r.illegal = 1'b1;
          end
        end
      end
      stk_pkg::stk_fetch_ptr: begin
        next_r.ptr = rf_rd_data;
        if (r.op == `STK_OPC_PUSH_DIRECT) begin
          next_r.data = rf_rd_data;
          next_r.state = stk_pkg::stk_update;
        end else begin
          // 82h names the source in the third byte, the others indirect
          if (is_user_push(r.op)) begin
            next_r.rf_ra = r.b2;
          end else begin
            next_r.rf_ra = rf_rd_data;
          end
          next_r.state = stk_pkg::stk_fetch_data;
        end
      end
      stk_pkg::stk_fetch_data: begin
        next_r.data = rf_rd_data;
        next_r.state = stk_pkg::stk_update;
      end
      stk_pkg::stk_update: begin
        if (is_sys_push(r.op)) begin
          next_r.system_stack_pointer =
            r.system_stack_pointer - 16'h0001;
        end else if (is_user_pop(r.op)) begin
          next_r.rf_we = 1'b1;
          next_r.rf_wa = r.b2;
          next_r.rf_wd = r.data;
        end else begin
          next_r.ptr = r.ptr - 8'h01;
          next_r.rf_we = 1'b1;
          next_r.rf_wa = r.b1;
          next_r.rf_wd = r.ptr - 8'h01;
        end
        next_r.state = stk_pkg::stk_store;
      end
      stk_pkg::stk_store: begin
        if (is_sys_push(r.op)) begin
          next_r.mem_we = 1'b1;
          next_r.mem_a = r.system_stack_pointer;
          next_r.mem_wd = r.data;
        end else if (is_user_pop(r.op)) begin
          // pointer written after the data so dst == pointer ends incremented
          next_r.rf_we = 1'b1;
          next_r.rf_wa = r.b1;
          next_r.rf_wd = r.ptr + 8'h01;
        end else begin
          next_r.rf_we = 1'b1;
          next_r.rf_wa = r.ptr;
          // a source that is the pointer itself already holds the new value
          if (r.b2 == r.b1) begin
            next_r.rf_wd = r.ptr;
          end else begin
            next_r.rf_wd = r.data;
          end
        end
        next_r.state = stk_pkg::stk_hold;
      end
      stk_pkg::stk_hold: begin
        if (r.cnt == `STK_INSTR_CYCLES) begin
          next_r.state = stk_pkg::stk_idle;
          next_r.cnt = 3'd0;
        end
      end
      default: begin
        next_r.state = stk_pkg::stk_idle;
        next_r.cnt = 3'd0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r.state <= stk_pkg::stk_idle;
      r.cnt <= 3'd0;
      r.op <= `STK_BYTE_RESET;
      r.b1 <= `STK_BYTE_RESET;
      r.b2 <= `STK_BYTE_RESET;
      r.ptr <= `STK_BYTE_RESET;
      r.data <= `STK_BYTE_RESET;
      r.system_stack_pointer <= `STK_STACK_POINTER_RESET;
      r.rf_we <= 1'b0;
      r.rf_wa <= `STK_BYTE_RESET;
      r.rf_wd <= `STK_BYTE_RESET;
      r.rf_ra <= `STK_BYTE_RESET;
      r.mem_we <= 1'b0;
      r.mem_a <= `STK_STACK_POINTER_RESET;
      r.mem_wd <= `STK_BYTE_RESET;
      r.illegal <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // no flag port exists: these instructions cannot disturb flags
  assign ready = (r.state == stk_pkg::stk_idle);
  assign done = (r.state == stk_pkg::stk_hold) &&
                (r.cnt == `STK_INSTR_CYCLES);
  assign illegal_op = r.illegal;
  // read data is used in the address's own cycle: the file must be async
  assign rf_rd_addr = r.rf_ra;
  assign rf_we = r.rf_we;
  assign rf_wr_addr = r.rf_wa;
  assign rf_wr_data = r.rf_wd;
  assign mem_we = r.mem_we;
  assign mem_addr = r.mem_a;
  assign mem_wr_data = r.mem_wd;
  assign stack_pointer_high_byte = r.system_stack_pointer[15:8];
  assign stack_pointer_low_byte = r.system_stack_pointer[7:0];

endmodule // stk_exec

// ==== stk_exec_checker.sv ====
`timescale 1ns/10ps
module stk_exec_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic ready,
  input wire logic done,
  input wire logic illegal_op,
  input wire logic rf_we,
  input wire logic mem_we,
  input wire logic stack_pointer_load,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire logic [7:0] rf_wr_addr,
  input wire logic [7:0] rf_wr_data,
  input wire logic [7:0] stack_pointer_high_byte,
  input wire logic [7:0] stack_pointer_low_byte,
  input wire logic [15:0] mem_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] o1, o2;
  logic [15:0] s, stack_pointer;
  logic take, ok;
  assign take = start && ready;
  assign ok = opcode inside {8'h93, 8'h70, 8'h71, 8'h82};
  assign stack_pointer = {stack_pointer_high_byte, stack_pointer_low_byte};
  // operands and pointer as seen at the taking edge
  always_ff @(posedge core_clk) begin
    if (take) {o1, o2, s} <= {operand1, operand2, stack_pointer};
  end
  busy_span_a: assert property (take && ok |=>
    (!ready && !done)[*6] ##1 (done && !ready) ##1 ready)
    else $error("bad span");
  bad_opcode_a: assert property (take && !ok |=> illegal_op && ready)
    else $error("no illegal flag");
  pop_order_a: assert property (take && opcode == 8'h93 |-> ##4
    (rf_we && rf_wr_addr == o2) ##1 (rf_we && rf_wr_addr == o1))
    else $error("pop order");
  push_order_a: assert property (take && opcode == 8'h70 &&
    !stack_pointer_load |-> ##3 (stack_pointer == s - 16'h0001) ##1
    (mem_we && mem_addr == stack_pointer)) else $error("push order");
  ipush_order_a: assert property (take && opcode == 8'h71 &&
    !stack_pointer_load |-> ##4 (stack_pointer == s - 16'h0001) ##1
    (mem_we && mem_addr == stack_pointer))
    else $error("indirect push order");
  upush_order_a: assert property (take && opcode == 8'h82 |-> ##4
    (rf_we && rf_wr_addr == o1) ##1 (rf_we && rf_wr_addr == $past(rf_wr_data)))
    else $error("user push order");
  pointer_hold_a: assert property (ready && !stack_pointer_load |=>
    $stable(stack_pointer)) else $error("stack pointer moved");
  user_isolation_a: assert property (take &&
    opcode inside {8'h93, 8'h82} |=>
    !mem_we ##1 (!mem_we && $stable(stack_pointer))[*6])
    else $error("user op hit stack pointer");
  sys_rf_a: assert property (take && opcode[7:1] == 7'h38 |=>
    (!rf_we)[*7]) else $error("push wrote rf");
  cover property (take && opcode == 8'h93);
  cover property (take && opcode == 8'h82);
  cover property (take && opcode == 8'h71 && stack_pointer == 16'hFFFF);
  cover property (take && opcode == 8'h82 && operand1 == operand2);
  cover property (take && !ok);
endmodule // stk_exec_checker

bind stk_exec stk_exec_checker chk (.*);

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
  logic core_clk = 0, nrst = 0, start = 0, stack_pointer_load = 0;
  logic ready, done, illegal_op, rf_we, mem_we;
  logic [7:0] opcode = 0, operand1 = 0, operand2 = 0, rf_rd_addr, rf_rd_data;
  logic [7:0] rf_wr_addr, rf_wr_data, mem_wr_data, lmd;
  logic [7:0] stack_pointer_high_byte, stack_pointer_low_byte;
  logic [15:0] mem_addr, lma, stack_pointer_load_value = 0;
  logic [7:0] rf [256] = '{default: 8'h00};
  int num_errors = 0, num_checks = 0, cyc = 0;
  // op, op1, op2, rf addr/value, rf addr or stack value, stack pointer
  logic [71:0] rows [6] = '{72'h93_0002_0270_0002_0000,
    72'h82_1011_10FF_FFA5_0000, 72'h93_1020_20A5_1000_0000,
    72'h70_4000_404F_004F_FFFF, 72'h71_0000_0002_0070_FFFE,
    72'h82_0000_0001_0101_FFFE};
  stk_exec dut (.*);
  always #25 core_clk = ~core_clk;
  assign rf_rd_data = rf[rf_rd_addr];
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (rf_we) rf[rf_wr_addr] <= rf_wr_data;
    if (mem_we) {lma, lmd} <= {mem_addr, mem_wr_data};
    if (cyc == 2000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [23:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [7:0] op, a, b);
    int n;
    n = 0;
    @(posedge core_clk);
    {start, opcode, operand1, operand2} <= {1'b1, op, a, b};
    @(posedge core_clk);
    start <= 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    chk(24'(n), 24'd7);
    @(negedge core_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {rf[8'h00], rf[8'h01], rf[8'h11], rf[8'h40]} = 32'h0170_A54F;
    repeat (8) @(posedge core_clk);
    nrst <= 1;
    foreach (rows[i]) begin
      logic [71:0] r;
      r = rows[i];
      run(r[71:64], r[63:56], r[55:48]);
      chk(rf[r[47:40]], r[39:32]);
      if (r[71:68] == 4'h7) chk({lma, lmd}, {r[15:0], r[23:16]});
      else chk(rf[r[31:24]], r[23:16]);
      chk({stack_pointer_high_byte, stack_pointer_low_byte}, r[15:0]);
      $display("row %0d done", i);
    end
    // the incrementing push is not handled here and must be refused
    @(posedge core_clk);
    {start, opcode} <= {1'b1, 8'h83};
    @(posedge core_clk);
    start <= 0;
    @(negedge core_clk);
    chk({illegal_op, ready, rf_we, mem_we}, 24'hC);
    $display("illegal done");
    @(posedge core_clk);
    {stack_pointer_load, stack_pointer_load_value} <= {1'b1, 16'h0100};
    @(posedge core_clk);
    stack_pointer_load <= 0;
    run(8'h70, 8'h40, 8'h00);
    chk({lma, lmd}, 24'h00_FF4F);
    $display("reload done");
    // reset in mid-instruction must abandon it cleanly
    @(posedge core_clk);
    {start, opcode} <= {1'b1, 8'h71};
    repeat (3) @(posedge core_clk);
    {start, nrst} <= 2'b00;
    @(posedge core_clk);
    nrst <= 1;
    @(negedge core_clk);
    chk({ready, stack_pointer_high_byte, stack_pointer_low_byte},
        24'h1_0000);
    $display("reset done");
    wrap_up();
  end
endmodule // tb
